// *** hw/hsp_status_port.sv ***
// Purpose: Status word, buffer configuration and port D buffering.
// Assumes: Plain register port with read data one cycle after the read strobe.
// Notes:   Mode register stands in for the configuration bits held elsewhere.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ns
module hsp_status_port #(
  parameter int          PORT_W    = 8,
  parameter logic        LEGACY_ID = 1'b0
) (
  input  wire logic               clock,
  input  wire logic               rst_n,
  input  wire hsp_pkg::hsp_req_t  bus_req,
  output logic [15:0]             rdata,
  input  wire hsp_pkg::hsp_pins_t pins_in,
  input  wire logic [PORT_W-1:0]  port_d_in,
  output logic [PORT_W-1:0]       port_d_out,
  output logic                    port_d_oe_n,
  output logic                    counter1_gate,
  output logic                    counter2_gate,
  output logic                    new_feature_enable,
  output logic                    group1_tc_irq,
  output logic                    group2_tc_irq
);
  import hsp_pkg::*;

  initial begin
    if (PORT_W < 1 || PORT_W > HSP_DW) begin
      $error("Port width out of range.");
    end
  end

  // ----------------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------------
  hsp_pins_t          pins_s;
  logic [PORT_W-1:0]  port_d_s;

  hsp_sync #(.W($bits(hsp_pins_t))) u_sync_pins (
    .clock    (clock),
    .rst_n    (rst_n),
    .async_in (pins_in),
    .sync_out (pins_s)
  );

  hsp_sync #(.W(PORT_W)) u_sync_port (
    .clock    (clock),
    .rst_n    (rst_n),
    .async_in (port_d_in),
    .sync_out (port_d_s)
  );

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  wire wr_cfg    = bus_req.wr && (bus_req.addr == HSP_OFS_CFG);
  wire wr_mode   = bus_req.wr && (bus_req.addr == HSP_OFS_MODE);
  wire wr_port   = bus_req.wr && (bus_req.addr == HSP_OFS_PORT_D);
  wire wr_cntclr = bus_req.wr && (bus_req.addr == HSP_OFS_CNT_CLR);
  wire wr_tc1clr = bus_req.wr && (bus_req.addr == HSP_OFS_TC1_CLR);
  wire wr_tc2clr = bus_req.wr && (bus_req.addr == HSP_OFS_TC2_CLR);
  wire rd_stat   = bus_req.rd && (bus_req.addr == HSP_OFS_STATUS);
  wire rd_port   = bus_req.rd && (bus_req.addr == HSP_OFS_PORT_D);
  wire rd_mode   = bus_req.rd && (bus_req.addr == HSP_OFS_MODE);

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  logic        dbl_buf_q;
  logic        new_feat_q;
  logic [15:0] mode_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dbl_buf_q  <= 1'b0;
      new_feat_q <= 1'b0;
      mode_q     <= HSP_ZERO16;
    end else begin
      if (wr_cfg) begin
        dbl_buf_q  <= bus_req.wdata[HSP_CFG_DBLBUF];
        new_feat_q <= bus_req.wdata[HSP_CFG_NEWFEAT];
      end
      if (wr_mode) begin
        mode_q <= bus_req.wdata;
      end
    end
  end

  // Double buffering is a newer-revision feature, so legacy mode ignores it.
  wire port_d_double_buffer_en = dbl_buf_q && new_feat_q;
  wire d_is_out     = mode_q[HSP_MODE_D_OUT];
  wire pulse_mode   = mode_q[HSP_MODE_PULSE];
  wire dual_dma_mode = mode_q[HSP_MODE_DUALDMA];
  assign new_feature_enable = new_feat_q;

  // ----------------------------------------------------------------------
  // Group 2 request qualification
  // ----------------------------------------------------------------------
  logic group2_request_prev_q;
  wire  group2_request_act  = pins_s.group2_request ^ mode_q[HSP_MODE_REQ_LO];
  wire  group2_request_edge = group2_request_act && !group2_request_prev_q;
  wire  group2_request_fire = pulse_mode ? group2_request_edge : group2_request_act;

  // ----------------------------------------------------------------------
  // Port D buffers
  // ----------------------------------------------------------------------
  logic [PORT_W-1:0] stage1_q;
  logic [PORT_W-1:0] stage2_q;
  logic [PORT_W-1:0] in_buf_q;
  logic              in_held_q;

  // In pulse mode a capture holds until the host reads the port.
  wire in_capture = port_d_double_buffer_en && !d_is_out && group2_request_fire &&
                    !(pulse_mode && in_held_q);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stage1_q    <= '0;
      stage2_q    <= '0;
      in_buf_q    <= '0;
      in_held_q   <= 1'b0;
      group2_request_prev_q <= 1'b0;
    end else begin
      group2_request_prev_q <= group2_request_act;
      if (wr_port) begin
        stage1_q <= bus_req.wdata[PORT_W-1:0];
      end
      if (!port_d_double_buffer_en && wr_port) begin
        stage2_q <= bus_req.wdata[PORT_W-1:0];
      end else if (port_d_double_buffer_en && d_is_out && group2_request_fire) begin
        stage2_q <= stage1_q;
      end
      if (in_capture) begin
        in_buf_q <= port_d_s;
      end
      if (in_capture && pulse_mode) begin
        in_held_q <= 1'b1;
      end else if (rd_port) begin
        in_held_q <= 1'b0;
      end
    end
  end

  assign port_d_out  = stage2_q;
  assign port_d_oe_n = !d_is_out;

  // ----------------------------------------------------------------------
  // Sticky event flags
  // ----------------------------------------------------------------------
  logic cnt3_prev_q;
  logic cnt3_flag_q;
  logic tc1_prev_q;
  logic tc2_prev_q;
  logic tc1_flag_q;
  logic tc2_flag_q;

  wire cnt3_rise = pins_s.counter3_out && !cnt3_prev_q;
  wire cnt3_set  = cnt3_rise && mode_q[HSP_MODE_CNT3IE];
  wire tc1_set   = pins_s.group1_terminal_count && !tc1_prev_q;
  wire tc2_set   = pins_s.group2_terminal_count && !tc2_prev_q;

  // A set arriving with its clear wins, so no event is lost.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt3_prev_q <= 1'b0;
      tc1_prev_q  <= 1'b0;
      tc2_prev_q  <= 1'b0;
      cnt3_flag_q <= 1'b0;
      tc1_flag_q  <= 1'b0;
      tc2_flag_q  <= 1'b0;
    end else begin
      cnt3_prev_q <= pins_s.counter3_out;
      tc1_prev_q  <= pins_s.group1_terminal_count;
      tc2_prev_q  <= pins_s.group2_terminal_count;
      cnt3_flag_q <= cnt3_set || (cnt3_flag_q && !wr_cntclr);
      tc1_flag_q  <= tc1_set || (tc1_flag_q && !wr_tc1clr);
      tc2_flag_q  <= tc2_set || (tc2_flag_q && !wr_tc2clr);
    end
  end

  assign group1_tc_irq = tc1_flag_q && mode_q[HSP_MODE_TC1IE];
  assign group2_tc_irq = tc2_flag_q && mode_q[HSP_MODE_TC2IE];

  // ----------------------------------------------------------------------
  // Counter gates and status word
  // ----------------------------------------------------------------------
  assign counter1_gate = pins_s.extra_input_one && mode_q[HSP_MODE_COUNTER1_ENABLE];
  assign counter2_gate = pins_s.extra_input_two && mode_q[HSP_MODE_CNT2EN];

  wire g1_ready = mode_q[HSP_MODE_G1_WR] ? pins_s.group1_transfer_ready
                : (mode_q[HSP_MODE_G1_HS] && pins_s.group1_transfer_ready);
  wire g2_ready = mode_q[HSP_MODE_G2_WR] ? pins_s.group2_transfer_ready
                : (mode_q[HSP_MODE_G2_HS] && pins_s.group2_transfer_ready);

  // Bit 13 and bit 3 read as zero.
  wire [15:0] status_word = {
    dual_dma_mode && mode_q[HSP_MODE_CHSEL],
    cnt3_flag_q,
    1'b0,
    mode_q[HSP_MODE_WIDE],
    pins_s.extra_input_one,
    tc2_flag_q,
    tc1_flag_q,
    g1_ready,
    pins_s.group1_request,
    pins_s.group1_acknowledge,
    pins_s.extra_input_two,
    LEGACY_ID,
    1'b0,
    g2_ready,
    pins_s.group2_request,
    pins_s.group2_acknowledge
  };

  wire [PORT_W-1:0] port_view = d_is_out ? stage2_q
                              : (port_d_double_buffer_en ? in_buf_q : port_d_s);

  wire [15:0] port_word = {{(HSP_DW-PORT_W){1'b0}}, port_view};

  // Unmapped and write-only offsets read as zero.
  wire [15:0] rdata_d = rd_stat ? status_word :
                        rd_port ? port_word   :
                        rd_mode ? mode_q      : HSP_ZERO16;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= HSP_ZERO16;
    end else begin
      rdata <= rdata_d;
    end
  end
endmodule : hsp_status_port

// *** hw/hsp_pkg.sv ***
// Purpose: Constants and carrier types for the handshake status and port buffer block.
// Assumes: 16-bit register port, one clock, asynchronous active-low reset.
// Notes:   Offsets are word offsets on the plain register port.
package hsp_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [4:0]  HSP_OFS_STATUS   = 5'h00;
  localparam logic [4:0]  HSP_OFS_CNT_CLR  = 5'h0A;
  localparam logic [4:0]  HSP_OFS_TC1_CLR  = 5'h0C;
  localparam logic [4:0]  HSP_OFS_TC2_CLR  = 5'h0E;
  localparam logic [4:0]  HSP_OFS_PORT_D   = 5'h09;
  localparam logic [4:0]  HSP_OFS_CFG      = 5'h14;
  localparam logic [4:0]  HSP_OFS_MODE     = 5'h1C;
  localparam int          HSP_AW           = 5;
  localparam int          HSP_DW           = 16;
  localparam logic [15:0] HSP_ZERO16       = 16'h0000;
  localparam logic [7:0]  HSP_ZERO8        = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int HSP_CFG_NEWFEAT  = 0;
  localparam int HSP_CFG_DBLBUF   = 1;
  localparam int HSP_MODE_D_OUT   = 0;
  localparam int HSP_MODE_PULSE   = 1;
  localparam int HSP_MODE_DUALDMA = 2;
  localparam int HSP_MODE_CNT3IE  = 3;
  localparam int HSP_MODE_TC1IE   = 4;
  localparam int HSP_MODE_TC2IE   = 5;
  localparam int HSP_MODE_COUNTER1_ENABLE  = 6;
  localparam int HSP_MODE_CNT2EN  = 7;
  localparam int HSP_MODE_REQ_LO  = 8;
  localparam int HSP_MODE_G1_WR   = 9;
  localparam int HSP_MODE_G2_WR   = 10;
  localparam int HSP_MODE_G1_HS   = 11;
  localparam int HSP_MODE_G2_HS   = 12;
  localparam int HSP_MODE_WIDE    = 13;
  localparam int HSP_MODE_CHSEL   = 14;

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic group1_request;
    logic group1_acknowledge;
    logic group2_request;
    logic group2_acknowledge;
    logic extra_input_one;
    logic extra_input_two;
    logic counter3_out;
    logic group1_terminal_count;
    logic group2_terminal_count;
    logic group1_transfer_ready;
    logic group2_transfer_ready;
  } hsp_pins_t;

  typedef struct packed {
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } hsp_req_t;

endpackage : hsp_pkg

// *** hw/hsp_sync.sv ***
// Purpose: Two-stage synchroniser, one per bit.
// Assumes: Inputs are asynchronous to clock.
// Notes:   First stage is read only by the second.
`timescale 1ns/1ns
module hsp_sync #(
  parameter int W = 8
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  initial begin
    if (W < 1) begin
      $error("Width must be at least one.");
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : hsp_sync

// *** sim/hsp_status_port_monitor.sv ***
// Purpose: Port-level assertions for the status and port buffer block.
// Assumes: Pins reach the status word two edges after they change.
// Notes:   Helper state follows the buffer configuration writes.
`timescale 1ns/1ns
module hsp_monitor #(
  parameter int   PORT_W    = 8,
  parameter logic LEGACY_ID = 1'b0
) (
  input wire logic               clock,
  input wire logic               rst_n,
  input wire hsp_pkg::hsp_req_t  bus_req,
  input wire logic [15:0]        rdata,
  input wire hsp_pkg::hsp_pins_t pins_in,
  input wire logic [PORT_W-1:0]  port_d_out,
  input wire logic               port_d_oe_n,
  input wire logic               counter1_gate,
  input wire logic               new_feature_enable,
  input wire logic               group1_tc_irq
);
  import hsp_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic dbl_q;
  wire  rd_stat = bus_req.rd && bus_req.addr == HSP_OFS_STATUS;
  wire  wr_cfg  = bus_req.wr && bus_req.addr == HSP_OFS_CFG;
  wire  wr_d    = bus_req.wr && bus_req.addr == HSP_OFS_PORT_D;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) dbl_q <= 1'b0;
    else if (wr_cfg) dbl_q <= bus_req.wdata[1] & bus_req.wdata[0];
  end
  // Six quiet samples leave no terminal-count edge in flight.
  sequence tc1_quiet_s;
    (!pins_in.group1_terminal_count) [*6];
  endsequence
  AST_NFE: assert property (wr_cfg |=> new_feature_enable == $past(bus_req.wdata[0]))
    else $error("compat bit wrong");
  AST_CFG_WO: assert property (bus_req.rd && bus_req.addr == HSP_OFS_CFG |=> rdata == 16'h0000)
    else $error("config readable");
  AST_REV: assert property (rd_stat |=> rdata[4] == LEGACY_ID && !rdata[13] && !rdata[3])
    else $error("fixed status bits wrong");
  AST_G1: assert property (rd_stat |=> rdata[7:6] == {$past(pins_in.group1_request, 3),
    $past(pins_in.group1_acknowledge, 3)}) else $error("group 1 lines wrong");
  AST_G2: assert property (rd_stat |=> rdata[1:0] == {$past(pins_in.group2_request, 3),
    $past(pins_in.group2_acknowledge, 3)}) else $error("group 2 lines wrong");
  AST_GATE1: assert property (counter1_gate |-> $past(pins_in.extra_input_one, 2))
    else $error("counter 1 gate ignores input");
  AST_TC1CLR: assert property (tc1_quiet_s ##0 (bus_req.wr && bus_req.addr == HSP_OFS_TC1_CLR)
    |=> !group1_tc_irq) else $error("terminal count not cleared");
  AST_UNBUF: assert property (wr_d && !port_d_oe_n && !dbl_q |=>
    port_d_out == $past(bus_req.wdata[PORT_W-1:0])) else $error("port D write not direct");
endmodule : hsp_monitor

// *** sim/hsp_peer.sv ***
// Purpose: Behavioural peripheral on the connector side.
// Assumes: Lines change only just after a rising clock edge.
// Notes:   A released data bus shows the inverse of its last value.
`timescale 1ns/1ns
module hsp_peer (
  input  wire logic          clock,
  input  wire logic [7:0]    port_d_out,
  input  wire logic          port_d_oe_n,
  output hsp_pkg::hsp_pins_t pins_in,
  output logic [7:0]         port_d_in
);
  import hsp_pkg::*;
  hsp_pins_t  pins_q  = '0;
  logic [7:0] data_q  = 8'h00;
  logic       drive_q = 1'b0;
  assign pins_in   = pins_q;
  assign port_d_in = !port_d_oe_n ? port_d_out : (drive_q ? data_q : ~data_q);
  task automatic set_lines(input hsp_pins_t v);
    @(posedge clock);
    pins_q <= v;
  endtask : set_lines
  // Data is held from before the request until after it drops.
  task automatic send(input logic [7:0] d);
    @(posedge clock);
    data_q  <= d;
    drive_q <= 1'b1;
    repeat (3) @(posedge clock);
    pins_q.group2_request <= 1'b1;
    repeat (3) @(posedge clock);
    pins_q.group2_request <= 1'b0;
    repeat (3) @(posedge clock);
    drive_q <= 1'b0;
  endtask : send
endmodule : hsp_peer

// *** sim/hsp_status_port_tb.sv ***
// Purpose: Self-checking bench for the status and port buffer block.
// Assumes: Default parameters, random request mode in the status loop, level request mode elsewhere except in the last port D tests, which use pulse mode.
// Notes:   Random modes keep counter and terminal-count inputs quiet.
`timescale 1ns/1ns
module hsp_status_port_tb;
  import hsp_pkg::*;
  localparam logic [10:0] FP [3] = '{11'h008, 11'h004, 11'h010};
  localparam int          FB [3] = '{9, 10, 14};
  localparam logic [4:0]  FA [3] = '{HSP_OFS_TC1_CLR, HSP_OFS_TC2_CLR, HSP_OFS_CNT_CLR};
  logic        clock   = 1'b0;
  logic        rst_n   = 1'b0;
  hsp_req_t    bus_req = '0;
  logic [15:0] rdata, mode, e;
  hsp_pins_t   pins_in, pv;
  logic [7:0]  port_d_in, port_d_out;
  logic        port_d_oe_n, counter1_gate, counter2_gate;
  logic        new_feature_enable, group1_tc_irq, group2_tc_irq;
  logic [31:0] rnd = 32'h0000_14ae;
  int          miscompares = 0;
  int          n_compared = 0;
  always #20 clock = ~clock;
  hsp_status_port u_dut (.clock(clock), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata),
    .pins_in(pins_in), .port_d_in(port_d_in), .port_d_out(port_d_out),
    .port_d_oe_n(port_d_oe_n), .counter1_gate(counter1_gate), .counter2_gate(counter2_gate),
    .new_feature_enable(new_feature_enable), .group1_tc_irq(group1_tc_irq),
    .group2_tc_irq(group2_tc_irq));
  hsp_peer u_peer (.clock(clock), .port_d_out(port_d_out), .port_d_oe_n(port_d_oe_n),
    .pins_in(pins_in), .port_d_in(port_d_in));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  function automatic logic [15:0] exp_stat(input logic [15:0] m, input hsp_pins_t p);
    return {m[2] & m[14], 2'b00, m[13], p.extra_input_one, 2'b00,
      p.group1_transfer_ready & (m[9] | m[11]), p.group1_request, p.group1_acknowledge,
      p.extra_input_two, 2'b00, p.group2_transfer_ready & (m[10] | m[12]),
      p.group2_request, p.group2_acknowledge};
  endfunction : exp_stat
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic [4:0] a, input logic [15:0] d, input logic w);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clock);
    bus_req <= '0;
  endtask : bus
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    bus(a, 16'h0000, 1'b0);
    #1 chk(rdata, exp);
  endtask : rd
  task automatic final_report;
    if (miscompares == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    final_report();
  end
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    #1 chk({14'h0, new_feature_enable, port_d_oe_n}, 16'h0001);
    rd(HSP_OFS_CFG, 16'h0000);
    rd(5'h1F, 16'h0000);
    for (int i = 0; i < 24; i++) begin
      rnd = xs(rnd);
      mode = rnd[15:0] & 16'h7FFF;
      pv = hsp_pins_t'(rnd[26:16] & 11'h7E3);
      bus(HSP_OFS_MODE, mode, 1'b1);
      u_peer.set_lines(pv);
      repeat (4) @(posedge clock);
      rd(HSP_OFS_STATUS, exp_stat(mode, pv));
      e = {14'h0, pv.extra_input_two & mode[7], pv.extra_input_one & mode[6]};
      chk({14'h0, counter2_gate, counter1_gate}, e);
    end
    bus(HSP_OFS_MODE, 16'h0038, 1'b1);
    for (int k = 0; k < 3; k++) begin
      u_peer.set_lines(hsp_pins_t'(FP[k]));
      repeat (5) @(posedge clock);
      rd(HSP_OFS_STATUS, 16'h0001 << FB[k]);
      rd(HSP_OFS_STATUS, 16'h0001 << FB[k]);
      chk({14'h0, group2_tc_irq, group1_tc_irq}, {14'h0, k == 1, k == 0});
      u_peer.set_lines(hsp_pins_t'(11'h000));
      repeat (6) @(posedge clock);
      bus(FA[k], 16'hFFFF, 1'b1);
      repeat (4) @(posedge clock);
      rd(HSP_OFS_STATUS, 16'h0000);
    end
    bus(HSP_OFS_MODE, 16'h0001, 1'b1);
    bus(HSP_OFS_CFG, 16'h0003, 1'b1);
    bus(HSP_OFS_PORT_D, 16'h0055, 1'b1);
    repeat (4) @(posedge clock);
    #1 chk({8'h00, port_d_out}, 16'h0000);
    u_peer.set_lines(hsp_pins_t'(11'h100));
    repeat (2) @(posedge clock);
    u_peer.set_lines(hsp_pins_t'(11'h000));
    repeat (4) @(posedge clock);
    #1 chk({8'h00, port_d_out}, 16'h0055);
    bus(HSP_OFS_CFG, 16'h0001, 1'b1);
    bus(HSP_OFS_PORT_D, 16'h00A6, 1'b1);
    #1 chk({8'h00, port_d_out}, 16'h00A6);
    bus(HSP_OFS_CFG, 16'h0002, 1'b1);
    bus(HSP_OFS_PORT_D, 16'h003C, 1'b1);
    #1 chk({8'h00, port_d_out}, 16'h003C);
    bus(HSP_OFS_MODE, 16'h0000, 1'b1);
    bus(HSP_OFS_CFG, 16'h0003, 1'b1);
    u_peer.send(8'h96);
    repeat (4) @(posedge clock);
    rd(HSP_OFS_PORT_D, 16'h0096);
    bus(HSP_OFS_CFG, 16'h0001, 1'b1);
    repeat (4) @(posedge clock);
    rd(HSP_OFS_PORT_D, 16'h0069);
    bus(HSP_OFS_MODE, 16'h0002, 1'b1);
    bus(HSP_OFS_CFG, 16'h0003, 1'b1);
    u_peer.send(8'h5A);
    u_peer.send(8'h33);
    repeat (4) @(posedge clock);
    rd(HSP_OFS_PORT_D, 16'h005A);
    u_peer.send(8'hC3);
    repeat (4) @(posedge clock);
    rd(HSP_OFS_PORT_D, 16'h00C3);
    final_report();
  end
endmodule : hsp_status_port_tb
bind hsp_status_port hsp_monitor #(.PORT_W(PORT_W), .LEGACY_ID(LEGACY_ID)) u_mon (
  .clock(clock), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata), .pins_in(pins_in),
  .port_d_out(port_d_out), .port_d_oe_n(port_d_oe_n), .counter1_gate(counter1_gate),
  .new_feature_enable(new_feature_enable), .group1_tc_irq(group1_tc_irq));
